// File: rtl/rcs_slave.sv
// Purpose: Serial configuration slave of a low-power transmitter.
// Assumes: SPI mode 0 master; sclk idle low; core logic on clk.
// Notes: Link logic runs on sclk, core on clk; events cross by toggle.
// Functional notes
// RULE1: All bytes shifted most significant bit first.
// RULE2: Header: read/write, burst, six-bit address.
// RULE3: Chip select high abandons the transfer.
// RULE4: Master waits for output low first.
// RULE5: Output low at once unless not ready.
// RULE6: Status byte returned while header shifts.
// RULE7: Status bit 7 is active-low not ready; the code drives it high while not ready.
// RULE8: Status bits 6:4 show main state.
// RULE9: State codes fixed; underflow cleared by flush.
// RULE10: Bits 3:0 free bytes, saturate at 15.
// RULE11: Free count is before byte in progress.
// RULE12: Config addresses 00-2F readable and writable.
// RULE13: Each written data byte returns status.
// RULE14: Burst address counter advances every byte.
// RULE15: 30-3D: burst picks status, else strobe; the code strobes only on single writes and ignores single reads and burst writes.
// RULE16: Status registers only read singly.
// RULE17: Strobe is header only, no data.
// RULE18: New header may follow a strobe.
// RULE19: Power-down, oscillator-off strobes wait for deselect.
// RULE20: Address 3F write reaches 64-byte FIFO.
// RULE21: Single FIFO access carries one byte.
// RULE22: Burst FIFO access runs until deselect.
// RULE23: Flush strobe empties the FIFO.
// RULE24: Sleep empties the FIFO.
// RULE25: Change frequency only while idle.
// RULE26: Sample on rising, drive on falling.
`timescale 1ns/1ns
`include "rcs_params.svh"

module rcs_slave
#(
    parameter int DEPTH = `RCS_FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic osc_ok,
    input wire logic supply_ok,
    input wire logic sleep_state,
    input wire logic [2:0] radio_state,
    input wire logic [`RCS_NSTAT*8-1:0] stat_regs,
    input wire logic tx_pop,
    output logic [7:0] tx_data,
    output logic tx_ack,
    output logic strobe,
    output logic [5:0] strobe_addr,
    input wire logic [5:0] cfg_rd_addr,
    output logic [7:0] cfg_rd_data,
    output logic not_ready_flag
)
;
    localparam int AW = $clog2(DEPTH);

    // Free count field is 7 bits wide, so depth is bounded
    generate
        if (DEPTH < 16 || DEPTH > 64 || (1 << AW) != DEPTH)
            $error("rcs_slave: DEPTH must be a power of two, 16..64");
    endgenerate

    // Link side
    logic frame_rst; // Deselect or reset clears the frame
    logic [2:0] bitc_q; // Bits taken in current byte
    logic [6:0] sh_q; // Shift-in register
    logic [7:0] rx_byte; // Byte as it completes
    logic byte_done; // Eighth rising edge
    rcs_pkg::rcs_spi_t st_q;
    rcs_pkg::rcs_spi_t st_d;
    logic [5:0] addr_q; // Burst address counter
    logic [5:0] addr_d;
    logic burst_q;
    logic burst_d;
    logic first_q; // First rising edge of the frame
    logic [6:0] snap_q; // Free bytes at frame start
    logic [6:0] fcnt_q; // FIFO bytes written this frame
    logic [6:0] fcnt_d;
    logic [7:0] out_q; // Byte being shifted out
    logic [7:0] out_d;
    logic so_q;
    logic [7:0] cfg_q [`RCS_NCFG]; // Readback copy
    logic ev_go; // Byte raises a core event
    rcs_pkg::rcs_ev_t ev_kind;
    logic ev_tog_q;
    rcs_pkg::rcs_ev_t ev_kind_q;
    logic [5:0] ev_addr_q;
    logic [7:0] ev_data_q;

    // Core side, frozen copies read by the link while selected
    logic [2:0] pub_state_q;
    logic [6:0] pub_free_q;
    logic [7:0] pub_stat_q [`RCS_NSTAT];

    // Header decode
    logic hdr_rw;
    logic hdr_bst;
    logic [5:0] hdr_a;
    logic is_cfg;
    logic is_stb;
    logic [3:0] stat_idx;

    function automatic logic [3:0] sat15(input logic [6:0] f);
        sat15 = (f >= `RCS_FREE_MIN) ? `RCS_FREE_SAT : f[3:0];
    endfunction

    assign frame_rst = chip_select_n | ~rst_n; // RULE3
    assign rx_byte = {sh_q, serial_in};
    assign byte_done = (bitc_q == 3'h7);
    assign hdr_rw = rx_byte[7]; // RULE2
    assign hdr_bst = rx_byte[6];
    assign hdr_a = rx_byte[5:0];
    assign is_cfg = (hdr_a <= `RCS_CFG_LAST);
    assign is_stb = (hdr_a >= `RCS_STB_FIRST) && (hdr_a <= `RCS_STB_LAST);
    assign stat_idx = 4'(hdr_a - `RCS_STB_FIRST);

    // Bit counter and input shifter, sampled on rising sclk
    always_ff @(posedge sclk or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            bitc_q <= 3'h0;
            sh_q <= 7'h00;
        end
        else
        begin
            bitc_q <= bitc_q + 3'h1;
            sh_q <= {sh_q[5:0], serial_in}; // RULE1 RULE26
        end
    end

    // Next frame state, address and outgoing byte
    always_comb
    begin
        st_d = st_q;
        addr_d = addr_q;
        burst_d = burst_q;
        fcnt_d = fcnt_q;
        ev_go = 1'b0;
        ev_kind = rcs_pkg::EV_REG;
        case (st_q)
            rcs_pkg::SPI_HDR:
            begin
                addr_d = hdr_a;
                burst_d = hdr_bst;
                if (is_cfg)
                    // RULE12
                    st_d = hdr_rw ? rcs_pkg::SPI_RD : rcs_pkg::SPI_WR;
                else if (is_stb && hdr_rw && hdr_bst)
                begin
                    st_d = rcs_pkg::SPI_RD; // RULE15
                    burst_d = 1'b0; // RULE16
                end
                else if (is_stb && !hdr_rw && !hdr_bst)
                begin
                    ev_go = 1'b1; // RULE17
                    ev_kind = rcs_pkg::EV_STROBE;
                    st_d = rcs_pkg::SPI_HDR; // RULE18
                end
                else if (hdr_a == `RCS_FIFO_ADDR && !hdr_rw)
                    st_d = rcs_pkg::SPI_FIFO; // RULE20
                else
                    // FIFO reads and unknown headers are ignored
                    st_d = rcs_pkg::SPI_DEAD;
            end
            rcs_pkg::SPI_WR:
            begin
                ev_go = 1'b1;
                ev_kind = rcs_pkg::EV_REG;
                if (!burst_q)
                    st_d = rcs_pkg::SPI_HDR;
                else if (addr_q < `RCS_CFG_LAST)
                    addr_d = addr_q + 6'h01; // RULE14
                else
                    // Burst ran off the config space
                    st_d = rcs_pkg::SPI_DEAD;
            end
            rcs_pkg::SPI_RD:
            begin
                if (burst_q && addr_q < `RCS_CFG_LAST)
                    addr_d = addr_q + 6'h01; // RULE14
                else if (burst_q)
                    st_d = rcs_pkg::SPI_DEAD;
                else
                    st_d = rcs_pkg::SPI_HDR; // RULE16
            end
            rcs_pkg::SPI_FIFO:
            begin
                ev_go = 1'b1;
                ev_kind = rcs_pkg::EV_FIFO;
                fcnt_d = fcnt_q + 7'h01;
                if (!burst_q)
                    st_d = rcs_pkg::SPI_HDR; // RULE21
                // Burst stays until deselect
                // RULE22
            end
            default:
                st_d = rcs_pkg::SPI_DEAD;
        endcase
        // Status for the next byte, free count before it lands
        out_d = {1'b0, pub_state_q, // RULE13
            sat15((snap_q > fcnt_d) ? snap_q - fcnt_d : 7'h00)}; // RULE11
        if (st_d == rcs_pkg::SPI_RD && st_q == rcs_pkg::SPI_HDR)
            out_d = is_cfg ? cfg_q[hdr_a] : pub_stat_q[stat_idx];
        else if (st_d == rcs_pkg::SPI_RD)
            out_d = cfg_q[addr_d];
        else if (st_d == rcs_pkg::SPI_DEAD)
            out_d = 8'h00;
    end

    // Frame state, cleared on every deselect
    always_ff @(posedge sclk or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            st_q <= rcs_pkg::SPI_HDR; // RULE3
            addr_q <= 6'h00;
            burst_q <= 1'b0;
            fcnt_q <= 7'h00;
        end
        else if (byte_done)
        begin
            st_q <= st_d;
            addr_q <= addr_d;
            burst_q <= burst_d;
            fcnt_q <= fcnt_d;
        end
    end

    // Outgoing byte; status on the first edge of a frame
    always_ff @(posedge sclk or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            first_q <= 1'b1;
            snap_q <= 7'h00;
            out_q <= 8'h00;
        end
        else
        begin
            first_q <= 1'b0;
            if (first_q)
            begin
                snap_q <= pub_free_q;
                // RULE6 RULE7 RULE8 RULE10
                out_q <= {1'b0, pub_state_q, sat15(pub_free_q)};
            end
            else if (byte_done)
                out_q <= out_d;
        end
    end

    // Drive on falling sclk so the master samples on rising
    always_ff @(negedge sclk or posedge frame_rst)
    begin
        if (frame_rst)
            so_q <= 1'b0; // RULE5
        else
            so_q <= out_q[~bitc_q]; // RULE1 RULE26
    end

    // Not-ready overrides the pin; first bit needs no sclk edge
    assign serial_out = so_q | not_ready_flag; // RULE5 RULE7
    assign serial_out_oe = ~chip_select_n;

    // Readback copy of the config registers
    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `RCS_NCFG; i++)
                cfg_q[i] <= 8'h00;
        end
        else if (byte_done && st_q == rcs_pkg::SPI_WR)
            cfg_q[addr_q] <= rx_byte; // RULE12
    end

    // Event hold registers; stable for a whole byte time
    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_tog_q <= 1'b0;
            ev_kind_q <= rcs_pkg::EV_REG;
            ev_addr_q <= 6'h00;
            ev_data_q <= 8'h00;
        end
        else if (byte_done && ev_go && !chip_select_n)
        begin
            ev_tog_q <= ~ev_tog_q;
            ev_kind_q <= ev_kind;
            ev_addr_q <= (st_q == rcs_pkg::SPI_HDR) ? hdr_a : addr_q;
            ev_data_q <= rx_byte;
        end
    end

    // Core clock side
    logic cs_hi_s; // Synchronised deselect level
    logic cs_prev_q;
    logic cs_rise;
    logic ev_s;
    logic ev_prev_q;
    logic ev_hit;
    logic stb_hit;
    logic flush;
    logic [7:0] mem_q [DEPTH]; // Transmit FIFO storage
    logic [AW:0] wptr_q;
    logic [AW:0] rptr_q;
    logic [AW:0] cnt;
    logic undf_q; // Underflow seen, held until flush
    logic pend_q; // Deferred strobe waiting for deselect
    logic [5:0] pend_a_q;
    logic [7:0] mirror_q [`RCS_NCFG];

    rcs_sync #(.W(1), .RST(1'b1)) u_cs_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .d(chip_select_n),
        .q(cs_hi_s)
    );

    rcs_sync #(.W(1), .RST(1'b0)) u_ev_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .d(ev_tog_q),
        .q(ev_s)
    );

    assign cs_rise = cs_hi_s & ~cs_prev_q;
    assign ev_hit = ev_s ^ ev_prev_q;
    assign stb_hit = ev_hit && ev_kind_q == rcs_pkg::EV_STROBE;
    assign cnt = wptr_q - rptr_q;
    assign flush = sleep_state // RULE24
        | (stb_hit && ev_addr_q == `RCS_FLUSH_ADDR); // RULE23

    // Edge memories and readiness
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_prev_q <= 1'b1;
            ev_prev_q <= 1'b0;
            not_ready_flag <= 1'b1;
        end
        else
        begin
            cs_prev_q <= cs_hi_s;
            ev_prev_q <= ev_s;
            not_ready_flag <= ~(osc_ok & supply_ok); // RULE7
        end
    end

    // Transmit FIFO pointers and pop; a flush outranks both ends
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
            tx_data <= 8'h00;
            tx_ack <= 1'b0;
        end
        else
        begin
            tx_ack <= 1'b0;
            if (flush)
            begin
                wptr_q <= '0; // RULE23 RULE24
                rptr_q <= '0;
            end
            else
            begin
                if (ev_hit && ev_kind_q == rcs_pkg::EV_FIFO
                    && cnt != (AW+1)'(DEPTH))
                begin
                    mem_q[wptr_q[AW-1:0]] <= ev_data_q; // RULE20
                    wptr_q <= wptr_q + (AW+1)'(1);
                end
                if (tx_pop && cnt != '0)
                begin
                    tx_data <= mem_q[rptr_q[AW-1:0]];
                    tx_ack <= 1'b1;
                    rptr_q <= rptr_q + (AW+1)'(1);
                end
            end
        end
    end

    // Underflow flag; a new underflow wins over a flush
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            undf_q <= 1'b0;
        else if (tx_pop && cnt == '0)
            undf_q <= 1'b1;
        else if (flush)
            undf_q <= 1'b0; // RULE9
    end

    // Status copies frozen while selected so the link reads them safely
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pub_state_q <= `RCS_ST_IDLE;
            pub_free_q <= 7'(DEPTH);
            for (int i = 0; i < `RCS_NSTAT; i++)
                pub_stat_q[i] <= 8'h00;
        end
        else if (cs_hi_s)
        begin
            // RULE8 RULE9
            pub_state_q <= undf_q ? `RCS_ST_TXUF : radio_state;
            pub_free_q <= 7'((AW+1)'(DEPTH) - cnt); // RULE10
            for (int i = 0; i < `RCS_NSTAT; i++)
                pub_stat_q[i] <= stat_regs[i*8 +: 8];
        end
    end

    // Strobe issue; two strobes wait for deselect
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strobe <= 1'b0;
            strobe_addr <= 6'h00;
            pend_q <= 1'b0;
            pend_a_q <= 6'h00;
        end
        else
        begin
            strobe <= 1'b0;
            if (stb_hit && (ev_addr_q == `RCS_PWRDN_ADDR
                || ev_addr_q == `RCS_OSCOFF_ADDR))
            begin
                pend_q <= 1'b1; // RULE19
                pend_a_q <= ev_addr_q;
            end
            else if (stb_hit)
            begin
                strobe <= 1'b1; // RULE19
                strobe_addr <= ev_addr_q;
            end
            else if (cs_rise && pend_q)
            begin
                strobe <= 1'b1; // RULE19
                strobe_addr <= pend_a_q;
                pend_q <= 1'b0;
            end
        end
    end

    // Core copy of the config registers and its read port
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `RCS_NCFG; i++)
                mirror_q[i] <= 8'h00;
            cfg_rd_data <= 8'h00;
        end
        else
        begin
            if (ev_hit && ev_kind_q == rcs_pkg::EV_REG)
                mirror_q[ev_addr_q] <= ev_data_q; // RULE12
            cfg_rd_data <= (cfg_rd_addr <= `RCS_CFG_LAST)
                ? mirror_q[cfg_rd_addr] : 8'h00;
        end
    end

    // Checks on the link and on the core side
    sequence s_strobe_hdr;
        st_q == rcs_pkg::SPI_HDR && byte_done && !hdr_rw && !hdr_bst
            && is_stb;
    endsequence

    a_status_first: assert property (@(posedge sclk) // RULE7
        disable iff (frame_rst) first_q |-> serial_out == not_ready_flag
            ##1 out_q[7] == 1'b0 && out_q[6:4] == $past(pub_state_q))
        else $error("status byte head wrong");

    a_free_sat: assert property (@(posedge sclk) // RULE10
        disable iff (frame_rst) first_q && pub_free_q >= 7'h0F
            |=> out_q[3:0] == 4'hF)
        else $error("free count not saturated");

    a_strobe_rehdr: assert property (@(posedge sclk) // RULE18
        disable iff (frame_rst) s_strobe_hdr
            |=> st_q == rcs_pkg::SPI_HDR && ev_tog_q != $past(ev_tog_q))
        else $error("strobe did not return to header");

    a_fifo_enter: assert property (@(posedge sclk) // RULE20
        disable iff (frame_rst) st_q == rcs_pkg::SPI_HDR && byte_done
            && rx_byte == 8'h3F |=> st_q == rcs_pkg::SPI_FIFO)
        else $error("fifo header not decoded");

    a_fifo_single: assert property (@(posedge sclk) // RULE21
        disable iff (frame_rst) st_q == rcs_pkg::SPI_FIFO && byte_done
            && !burst_q |=> st_q == rcs_pkg::SPI_HDR)
        else $error("single fifo access overran");

    a_burst_addr: assert property (@(posedge sclk) // RULE14
        disable iff (frame_rst) st_q == rcs_pkg::SPI_WR && byte_done
            && burst_q && addr_q < 6'h2F
            |=> addr_q == $past(addr_q) + 6'h01 ##1 addr_q == $past(addr_q))
        else $error("burst address not advanced");

    a_stat_single: assert property (@(posedge sclk) // RULE16
        disable iff (frame_rst) st_q == rcs_pkg::SPI_HDR && byte_done
            && is_stb && hdr_rw && hdr_bst
            |=> !burst_q ##8 st_q == rcs_pkg::SPI_HDR)
        else $error("status read not single");

    a_flush_empty: assert property (@(posedge clk) // RULE23
        disable iff (!rst_n) flush && !tx_pop |=> cnt == '0 && !undf_q)
        else $error("flush did not empty fifo");

    a_defer_strobe: assert property (@(posedge clk) // RULE19
        disable iff (!rst_n) cs_rise && pend_q && !stb_hit
            |=> strobe && strobe_addr == $past(pend_a_q))
        else $error("deferred strobe not issued");
endmodule

// File: rtl/rcs_params.svh
// Purpose: Constants for the radio configuration serial slave.
// Assumes: Included by bare name from rtl/ files.
// Notes: Addresses are 6-bit header addresses, state codes are 3-bit.
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// Address map of the header byte
`define RCS_CFG_LAST 6'h2F
`define RCS_STB_FIRST 6'h30
`define RCS_STB_LAST 6'h3D
`define RCS_FIFO_ADDR 6'h3F

// Storage sizes
`define RCS_FIFO_DEPTH 64
`define RCS_NSTAT 14
`define RCS_NCFG 48

// Free-byte field saturation
`define RCS_FREE_SAT 4'hF
`define RCS_FREE_MIN 7'h0F

// Main state codes reported in the status byte
`define RCS_ST_IDLE 3'h0
`define RCS_ST_TX 3'h2
`define RCS_ST_FSTX 3'h3
`define RCS_ST_CAL 3'h4
`define RCS_ST_SETTLE 3'h5
`define RCS_ST_TXUF 3'h7

// Strobe addresses with special handling
`define RCS_FLUSH_ADDR 6'h3B
`define RCS_PWRDN_ADDR 6'h39
`define RCS_OSCOFF_ADDR 6'h32

`endif

// File: rtl/rcs_pkg.sv
// Purpose: Types for the radio configuration serial slave.
// Assumes: Used as rcs_pkg::name, never imported.
// Notes: Frame states are one-hot.
package rcs_pkg;

    // Frame decoder states on the serial clock
    typedef enum logic [4:0]
    {
        SPI_HDR = 5'h01,
        SPI_WR = 5'h02,
        SPI_RD = 5'h04,
        SPI_FIFO = 5'h08,
        SPI_DEAD = 5'h10
    } rcs_spi_t;

    // Kind of event handed to the core clock
    typedef enum logic [1:0]
    {
        EV_REG = 2'h0,
        EV_FIFO = 2'h1,
        EV_STROBE = 2'h2
    } rcs_ev_t;

endpackage

// File: rtl/rcs_sync.sv
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Input comes from another clock domain or a pin.
// Notes: Output moves only when stages two and three agree.
`timescale 1ns/1ns

module rcs_sync
#(
    parameter int W = 1,
    parameter logic RST = 1'b0
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
)
;
    logic [W-1:0] s1_q; // Metastable stage, read by s2 only
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Shift chain
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= {W{RST}};
            s2_q <= {W{RST}};
            s3_q <= {W{RST}};
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a bit only once two late stages agree, filters one glitch
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= {W{RST}};
        else
            q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q);
    end
endmodule

// File: verif/rcs_master.sv
// Purpose: Mode 0 serial master model facing the radio config slave.
// Assumes: The bench opens and closes frames through the tasks below.
// Notes: Serial clock runs only inside frames, 64 ns per bit.
`timescale 1ns/1ns

module rcs_master
(
    output logic sclk,
    output logic chip_select_n,
    output logic serial_in,
    input wire logic serial_out
);
    // Idle: deselected, clock parked low
    initial
    begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
    end

    // Lower select only; held low for the whole access
    task automatic sel();
        chip_select_n = 1'b0;
    endtask

    // Bounded wait for the ready level, then the select setup time
    task automatic wait_rdy(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++)
        begin
            #10;
            ok = (serial_out === 1'b0);
        end
        #50;
    endtask

    // Shift n bits of tx, top bit first, capturing on rising edges
    task automatic xb(input logic [7:0] tx, input int n,
        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            serial_in = tx[i];
            #32 sclk = 1'b1;
            rx[i] = serial_out;
            #32 sclk = 1'b0;
        end
    endtask

    // Deselect; the data line is left changed so stale bits never help
    task automatic stop();
        #32 chip_select_n = 1'b1;
        serial_in = ~serial_in;
        #200;
    endtask
endmodule

// File: verif/tb_radio_config_spi_slave.sv
// Purpose: Self-checking bench for the radio config serial slave.
// Assumes: Master model drives the link; core pins driven here.
// Notes: Scenarios run in order and share the FIFO state left behind.
`timescale 1ns/1ns

module tb_radio_config_spi_slave;
    logic clk, rst_n, sclk, chip_select_n, serial_in, serial_out;
    logic serial_out_oe, osc_ok, supply_ok, sleep_state, tx_pop, tx_ack;
    logic strobe, not_ready_flag, ok;
    logic [2:0] radio_state;
    logic [111:0] stat_regs;
    logic [7:0] tx_data, cfg_rd_data, rx;
    logic [5:0] strobe_addr, cfg_rd_addr;
    int miscompares, n_compared, n_strobe, n0, cyc;

    rcs_slave rcs_slave_i (.clk, .rst_n, .sclk, .chip_select_n,
        .serial_in, .serial_out, .serial_out_oe, .osc_ok, .supply_ok,
        .sleep_state, .radio_state, .stat_regs, .tx_pop, .tx_data,
        .tx_ack, .strobe, .strobe_addr, .cfg_rd_addr, .cfg_rd_data,
        .not_ready_flag);
    // A released data line reads as pulled high at the master
    rcs_master rcs_master_i (.sclk, .chip_select_n, .serial_in,
        .serial_out(serial_out_oe ? serial_out : 1'b1));

    // Core clock, 100 MHz
    always #5 clk = ~clk;

    // Hang guard and strobe pulse counter
    always @(posedge clk)
    begin
        cyc++;
        if (strobe === 1'b1)
            n_strobe++;
        if (cyc == 30000)
        begin
            miscompares++;
            $display("Error timeout");
            close_out();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Short hands for the master model
    task automatic xb(input logic [7:0] t);
        rcs_master_i.xb(t, 8, rx);
    endtask
    task automatic open();
        rcs_master_i.sel();
        rcs_master_i.wait_rdy(ok);
        chk("ready", 8'h01, {7'h00, ok});
    endtask

    // One core pop request, answer looked at one clock later
    task automatic pop();
        @(posedge clk) tx_pop <= 1'b1;
        @(posedge clk) tx_pop <= 1'b0;
        #1;
    endtask

    task automatic t_write();
        @(posedge clk) radio_state <= 3'h0;
        open();
        xb(8'h6E);
        chk("hdr status", 8'h0F, rx);
        xb(8'h12);
        chk("wr status", 8'h0F, rx);
        xb(8'h34);
        chk("wr status", 8'h0F, rx);
        rcs_master_i.stop();
        open();
        xb(8'hAE);
        xb(8'h00);
        chk("rd 2E", 8'h12, rx);
        xb(8'hAF);
        xb(8'h00);
        chk("rd 2F", 8'h34, rx);
        rcs_master_i.stop();
        @(posedge clk) cfg_rd_addr <= 6'h2F;
        repeat (3) @(posedge clk);
        chk("core cfg", 8'h34, cfg_rd_data);
    endtask

    // A partial byte cut off by deselect must not land
    task automatic t_abort();
        open();
        xb(8'h50);
        xb(8'h3C);
        rcs_master_i.xb(8'hFF, 4, rx);
        rcs_master_i.stop();
        open();
        xb(8'hD0);
        xb(8'h00);
        chk("burst rd 10", 8'h3C, rx);
        xb(8'h00);
        chk("aborted 11", 8'h00, rx);
        rcs_master_i.stop();
        @(posedge clk) radio_state <= 3'h2;
    endtask

    // Fill all 64 places; free count is the one before each byte
    task automatic t_fifo();
        open();
        xb(8'h7F);
        for (int k = 0; k < 64; k++)
        begin
            xb(8'(k));
            chk("fifo free", k < 49 ? 8'h2F : 8'(8'h20 + 64 - k), rx);
        end
        rcs_master_i.stop();
        pop();
        chk("tx ack", 8'h01, {7'h00, tx_ack});
        chk("tx data", 8'h00, tx_data);
        open();
        xb(8'h3F);
        xb(8'hEE);
        chk("single free", 8'h21, rx);
        xb(8'h3F);
        xb(8'h77);
        chk("full free", 8'h20, rx);
        rcs_master_i.stop();
    endtask

    // Sleep empties; a pop on empty reports underflow
    task automatic t_sleep();
        @(posedge clk) sleep_state <= 1'b1;
        @(posedge clk) sleep_state <= 1'b0;
        repeat (4) @(posedge clk);
        pop();
        chk("empty pop", 8'h00, {7'h00, tx_ack});
        repeat (4) @(posedge clk);
        open();
        xb(8'hAE);
        chk("underflow", 8'h7F, rx);
        rcs_master_i.stop();
    endtask

    // Flush then a status read in the same frame
    task automatic t_strobe();
        n0 = n_strobe;
        open();
        xb(8'h3F);
        xb(8'h55);
        xb(8'h3B);
        xb(8'hF3);
        xb(8'h00);
        chk("status reg", 8'hA3, rx);
        xb(8'hAE);
        chk("after stat", 8'h7F, rx);
        rcs_master_i.stop();
        chk("strobe count", 8'h01, 8'(n_strobe - n0));
        chk("strobe addr", 8'h3B, {2'h0, strobe_addr});
        open();
        xb(8'hAE);
        chk("flushed state", 8'h2F, rx);
        rcs_master_i.stop();
        pop();
        chk("flushed fifo", 8'h00, {7'h00, tx_ack});
    endtask

    // Power-down strobe waits for deselect
    task automatic t_pwrdn();
        n0 = n_strobe;
        open();
        xb(8'h39);
        #300;
        chk("pd early", 8'h00, 8'(n_strobe - n0));
        rcs_master_i.stop();
        chk("pd late", 8'h01, 8'(n_strobe - n0));
        chk("pd addr", 8'h39, {2'h0, strobe_addr});
    endtask

    // Supply not stable keeps the output high
    task automatic t_notrdy();
        @(posedge clk) supply_ok <= 1'b0;
        repeat (4) @(posedge clk);
        rcs_master_i.sel();
        #100;
        chk("not ready pin", 8'h01, {7'h00, serial_out});
        chk("oe", 8'h01, {7'h00, serial_out_oe});
        chk("flag", 8'h01, {7'h00, not_ready_flag});
        rcs_master_i.stop();
        @(posedge clk) supply_ok <= 1'b1;
        repeat (4) @(posedge clk);
        open();
        xb(8'hAE);
        chk("ready bit", 8'h00, {7'h00, rx[7]});
        rcs_master_i.stop();
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        osc_ok = 1'b1;
        supply_ok = 1'b1;
        sleep_state = 1'b0;
        radio_state = 3'h2;
        stat_regs = 112'hADACABAAA9A8A7A6A5A4A3A2A1A0;
        tx_pop = 1'b0;
        cfg_rd_addr = 6'h00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        t_write();
        t_abort();
        t_fifo();
        t_sleep();
        t_strobe();
        t_pwrdn();
        t_notrdy();
        close_out();
    end
endmodule
